// *** ext_irq_consts.svh ***
// address map, field layout and timing constants of the external request block
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH
// ==================================
// register addresses
`define TRIG_LOW_ADDR   32'h56000088
`define TRIG_MID_ADDR   32'h5600008c
`define TRIG_HIGH_ADDR  32'h56000090
`define FILT_BASE_ADDR  32'h56000094
`define FILT_LAST_ADDR  32'h560000a0
`define IRQ_STAT_ADDR   32'h560000a4
`define IRQ_MASK_ADDR   32'h560000a8
// ==================================
// reset values and valid bits
`define CFG_RESET       32'h00000000
`define LOW_VALID_MASK  32'h77777777
// ==================================
// field layout
`define INPUTS_PER_REG  8
`define FIELD_STEP      4
`define METHOD_W        3
`define NOISE_FILTER_ENABLE_BIT       3
`define FILT_PER_REG    4
`define FILT_LANE       8
`define FILT_WIDTH_W    7
`define FILT_CLKSEL_BIT 7
`define UNFILTERED_CNT  8
// ==================================
// method codes
`define CODE_LOW        3'h0
`define CODE_HIGH       3'h1
`define CODE_FALL       2'h1
`define CODE_RISE       2'h2
`define CODE_BOTH       2'h3
// ==================================
// timing
`define CLK_PERIOD_NS   25
`define LVL_FILTER_NS   40
`define LVL_FILTER_CYC  ((`LVL_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** ext_irq_pkg.sv ***
// types shared by the external request block
package ext_irq_pkg;
  // ==================================
  // register port request
  typedef struct packed {
    logic [31:0] addr;   // byte address
    logic [31:0] wdata;  // write data
    logic        wr;     // write strobe
    logic        rd;     // read strobe
  } bus_req_type;
endpackage : ext_irq_pkg

// *** ext_irq_trigger_config.sv ***
// external interrupt request detection with trigger configuration registers
//
// Contract
// RULE_01: twenty-four request inputs, each individually configured
// RULE_02: code 000 low level, 001 high level
// RULE_03: code 01x requests on falling edge
// RULE_04: code 10x requests on rising edge
// RULE_05: code 11x both edges, upper inputs
// RULE_06: low register holds method fields inputs 0-7
// RULE_07: mid register holds method fields inputs 8-15
// RULE_08: filter enable bit above each upper field
// RULE_09: source holds level at least 40ns
// RULE_10: three config registers at consecutive words
// RULE_11: config registers reset to zero
// RULE_12: high register holds inputs 16-23, same layout
// RULE_13: filter clock select per filtered input
// RULE_14: seven-bit filter width per filtered input
// RULE_15: pins pass two synchroniser flip-flops
// RULE_16: unassigned low register bits read zero
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
`include "ext_irq_consts.svh"

module ext_irq_trigger_config #(
  parameter int NUM_INPUTS = 24
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire ext_irq_pkg::bus_req_type bus_req,
  output logic [31:0]                   rdata_q,
  input  wire logic [NUM_INPUTS-1:0]    external_request_input,
  input  wire logic                     filter_osc_clk,
  output logic [NUM_INPUTS-1:0]         request_q,
  output logic                          irq_q
);

  // ==================================
  // elaboration check
  // the register layout only serves exactly three banks of eight inputs
  if (NUM_INPUTS != 24) begin : g_bad_count
    $error("ext_irq_trigger_config: NUM_INPUTS must be 24");
  end

  localparam int NREG  = NUM_INPUTS / `INPUTS_PER_REG;   // trigger registers
  localparam int NFILT = (NUM_INPUTS - `UNFILTERED_CNT) / `FILT_PER_REG;
  localparam logic [`FILT_WIDTH_W-1:0] LVL_CYC = `FILT_WIDTH_W'(`LVL_FILTER_CYC);

  // ==================================
  // storage
  logic [31:0]               trig_q [NREG];        // method and filter enables
  logic [31:0]               filt_q [NFILT];       // filter clock and width
  logic [NUM_INPUTS-1:0]     stat_q;               // sticky request status
  logic [NUM_INPUTS-1:0]     mask_q;               // interrupt mask
  logic [NUM_INPUTS-1:0]     sync1_q;              // first synchroniser stage
  logic [NUM_INPUTS-1:0]     sync2_q;              // second synchroniser stage
  logic [2:0]                osc_q;                // oscillator sync plus edge
  logic [NUM_INPUTS-1:0]     level_q;              // filtered pin level
  logic [NUM_INPUTS-1:0]     level_d;
  logic [NUM_INPUTS-1:0]     prev_q;               // filtered level, one cycle old
  logic [`FILT_WIDTH_W-1:0]  cnt_q [NUM_INPUTS];   // stability counters
  logic [`FILT_WIDTH_W-1:0]  cnt_d [NUM_INPUTS];
  logic [NUM_INPUTS-1:0]     request_d;            // raw request per input
  logic                      osc_tick;             // one pulse per oscillator rising edge seen by clk

  // ==================================
  // functions
  // register index of a mapped address, or -1
  function automatic int reg_index(input logic [31:0] a);
    int idx;
    idx = -1;
    if (a == `TRIG_LOW_ADDR) idx = 0;
    else if (a == `TRIG_MID_ADDR) idx = 1;
    else if (a == `TRIG_HIGH_ADDR) idx = 2;
    else if (a >= `FILT_BASE_ADDR && a <= `FILT_LAST_ADDR && a[1:0] == 2'h0)
      idx = 3 + int'((a - `FILT_BASE_ADDR) >> 2);
    else if (a == `IRQ_STAT_ADDR) idx = 7;
    else if (a == `IRQ_MASK_ADDR) idx = 8;
    return idx;
  endfunction : reg_index

  // request from method code and filtered level
  function automatic logic detect(input logic [2:0] code, input logic lvl,
                                  input logic old, input logic both_ok);
    logic r;
    r = 1'b0;
    if (code == `CODE_LOW) r = ~lvl;                              // RULE_02
    else if (code == `CODE_HIGH) r = lvl;                         // RULE_02
    else begin
      case (code[2:1])
        `CODE_FALL: r = old & ~lvl;                               // RULE_03
        `CODE_RISE: r = ~old & lvl;                               // RULE_04
        `CODE_BOTH: r = both_ok & (old ^ lvl);                    // RULE_05
        default:    r = 1'b0;
      endcase
    end
    return r;
  endfunction : detect

  // ==================================
  // pin synchronisers
  // only sync2 is read by logic; sync1 may go metastable
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= external_request_input;                          // RULE_15
      sync2_q <= sync1_q;                                         // RULE_15
    end
  end

  // oscillator clock used as a sampled tick, not a second domain
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_q <= '0;
    end else begin
      osc_q <= {osc_q[1:0], filter_osc_clk};
    end
  end

  assign osc_tick = osc_q[1] & ~osc_q[2];

  // ==================================
  // noise filters
  // a change is taken only after the pin stays changed for width ticks;
  // lower inputs always use a fixed filter of one level-hold time
  always_comb begin
    int k;
    int l;
    logic [`FILT_WIDTH_W-1:0] wid;
    logic tick;
    k = 0;
    l = 0;
    wid = '0;
    tick = 1'b1;
    level_d = level_q;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      cnt_d[i] = cnt_q[i];
      if (i < `UNFILTERED_CNT) begin
        wid = LVL_CYC;                                            // RULE_09
        tick = 1'b1;
      end else begin
        k = (i - `UNFILTERED_CNT) / `FILT_PER_REG;
        l = ((i - `UNFILTERED_CNT) % `FILT_PER_REG) * `FILT_LANE;
        // disabled filter means a zero width
        if (trig_q[i / `INPUTS_PER_REG][(i % `INPUTS_PER_REG) * `FIELD_STEP + `NOISE_FILTER_ENABLE_BIT]) // RULE_08
          wid = filt_q[k][l +: `FILT_WIDTH_W];                    // RULE_14
        else
          wid = '0;
        tick = filt_q[k][l + `FILT_CLKSEL_BIT] ? osc_tick : 1'b1; // RULE_13
      end
      if (sync2_q[i] == level_q[i]) begin
        cnt_d[i] = '0;
      end else if (wid == '0) begin
        level_d[i] = sync2_q[i];
      end else if (tick) begin
        if (cnt_q[i] + `FILT_WIDTH_W'(1) >= wid) begin
          level_d[i] = sync2_q[i];
          cnt_d[i] = '0;
        end else begin
          cnt_d[i] = cnt_q[i] + `FILT_WIDTH_W'(1);
        end
      end
    end
  end

  // filter state
  always_ff @(posedge clk) begin
    if (srst) begin
      level_q <= '0;
      prev_q  <= '0;
      for (int i = 0; i < NUM_INPUTS; i++) cnt_q[i] <= '0;
    end else begin
      level_q <= level_d;
      prev_q  <= level_q;
      for (int i = 0; i < NUM_INPUTS; i++) cnt_q[i] <= cnt_d[i];
    end
  end

  // ==================================
  // trigger detection
  always_comb begin
    for (int i = 0; i < NUM_INPUTS; i++) begin
      request_d[i] = detect(
        trig_q[i / `INPUTS_PER_REG][(i % `INPUTS_PER_REG) * `FIELD_STEP +: `METHOD_W], // RULE_01
        level_q[i], prev_q[i], i >= `UNFILTERED_CNT);             // RULE_05
    end
  end

  // request toward the interrupt controller; pulses for edges
  always_ff @(posedge clk) begin
    if (srst) begin
      request_q <= '0;
    end else begin
      request_q <= request_d;
    end
  end

  // ==================================
  // configuration registers
  // unassigned low register bits are never stored
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int r = 0; r < NREG; r++) trig_q[r] <= `CFG_RESET;    // RULE_11
      for (int r = 0; r < NFILT; r++) filt_q[r] <= `CFG_RESET;   // RULE_11
      mask_q <= '0;
    end else if (bus_req.wr) begin
      case (reg_index(bus_req.addr))
        0: trig_q[0] <= bus_req.wdata & `LOW_VALID_MASK;          // RULE_06 RULE_16
        1: trig_q[1] <= bus_req.wdata;                            // RULE_07
        2: trig_q[2] <= bus_req.wdata;                            // RULE_12
        3: filt_q[0] <= bus_req.wdata;
        4: filt_q[1] <= bus_req.wdata;
        5: filt_q[2] <= bus_req.wdata;
        6: filt_q[3] <= bus_req.wdata;
        8: mask_q <= bus_req.wdata[NUM_INPUTS-1:0];
        default: ;                                                // unmapped, and status (cleared below): ignored here
      endcase
    end
  end

  // ==================================
  // sticky status, write one to clear
  // a new request in the clearing cycle survives: set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_q <= '0;
    end else if (bus_req.wr && reg_index(bus_req.addr) == 7) begin
      stat_q <= (stat_q & ~bus_req.wdata[NUM_INPUTS-1:0]) | request_q;
    end else begin
      stat_q <= stat_q | request_q;
    end
  end

  // level interrupt while any unmasked status bit is set
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // ==================================
  // read port
  // data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (bus_req.rd) begin
      case (reg_index(bus_req.addr))
        0: rdata_q <= trig_q[0];                                  // RULE_10 RULE_16
        1: rdata_q <= trig_q[1];                                  // RULE_10
        2: rdata_q <= trig_q[2];                                  // RULE_10
        3: rdata_q <= filt_q[0];
        4: rdata_q <= filt_q[1];
        5: rdata_q <= filt_q[2];
        6: rdata_q <= filt_q[3];
        7: rdata_q <= 32'(stat_q);
        8: rdata_q <= 32'(mask_q);
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

endmodule : ext_irq_trigger_config

// *** ext_irq_trigger_config_asserts.sv ***
// port-level checks of the external request block
`timescale 1ns/100ps
`include "ext_irq_consts.svh"
module ext_irq_trigger_config_asserts #(
  parameter int NUM_INPUTS = 24
) (
  input wire logic                     clk,
  input wire logic                     srst,
  input wire ext_irq_pkg::bus_req_type bus_req,
  input wire logic [31:0]              rdata_q,
  input wire logic [NUM_INPUTS-1:0]    external_request_input,
  input wire logic                     filter_osc_clk,
  input wire logic [NUM_INPUTS-1:0]    request_q,
  input wire logic                     irq_q
);
  // ==================================
  // address decode helpers
  wire logic [31:0] a = bus_req.addr;                 // current address
  wire logic lo = a == `TRIG_LOW_ADDR;                // low config word
  wire logic mi = a == `TRIG_MID_ADDR;                // mid config word
  wire logic miss = a < `TRIG_LOW_ADDR || a > `IRQ_MASK_ADDR || a[1:0] != 2'h0;
  // ==================================
  // register port
  a_idle_read_zero: assert property (@(posedge clk) disable iff (srst) !bus_req.rd |=> rdata_q == 32'h0)
    else $error("read data not zero outside read");
  // write, one idle cycle, then read of the same word
  a_low_readback: assert property (@(posedge clk) disable iff (srst) bus_req.wr && lo ##1 !bus_req.wr
    ##1 bus_req.rd && lo |=> rdata_q == ($past(bus_req.wdata, 3) & `LOW_VALID_MASK))
    else $error("low word readback wrong");
  a_mid_readback: assert property (@(posedge clk) disable iff (srst) bus_req.wr && mi ##1 !bus_req.wr
    ##1 bus_req.rd && mi |=> rdata_q == $past(bus_req.wdata, 3))
    else $error("mid word readback wrong");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (srst) bus_req.rd && miss |=> rdata_q == 32'h0)
    else $error("unmapped read not zero");
  // ==================================
  // reset and pin path
  a_reset_clears: assert property (@(posedge clk) srst |=> request_q == '0 && !irq_q && rdata_q == 32'h0)
    else $error("outputs not cleared by reset");
  // first edge out of reset still sees cleared sync stages: low-level mode requests everywhere
  a_sync_lag: assert property (@(posedge clk) disable iff (srst) $fell(srst) |=> request_q == '1)
    else $error("request faster than synchroniser");
  // ==================================
  // interrupt output
  a_irq_cause: assert property (@(posedge clk) disable iff (srst) $rose(irq_q) |->
    $past(|request_q, 2) || $past(bus_req.wr, 2) || $past(bus_req.wr, 3)) else $error("irq rose without cause");
  a_irq_drop: assert property (@(posedge clk) disable iff (srst) $fell(irq_q) |->
    $past(bus_req.wr, 2) || $past(bus_req.wr, 3)) else $error("irq fell without write");
endmodule : ext_irq_trigger_config_asserts

bind ext_irq_trigger_config ext_irq_trigger_config_asserts #(.NUM_INPUTS(NUM_INPUTS)) u_chk (.clk(clk), .srst(srst),
  .bus_req(bus_req), .rdata_q(rdata_q), .external_request_input(external_request_input),
  .filter_osc_clk(filter_osc_clk), .request_q(request_q), .irq_q(irq_q));

// *** ext_irq_source.sv ***
// model of the external devices driving the request pins
`timescale 1ns/100ps
module ext_irq_source (
  input  wire logic        clk,
  input  wire logic [23:0] level_cmd,
  output logic [23:0]      external_request_input,
  output logic             filter_osc_clk
);
  initial external_request_input = 24'h0;
  initial filter_osc_clk = 1'b0;
  // oscillator runs free, unrelated in phase to clk
  always #17.3 filter_osc_clk = ~filter_osc_clk;
  // sources launch a level after an edge and hold it for whole cycles
  always @(posedge clk) external_request_input <= level_cmd;
endmodule : ext_irq_source

// *** ext_irq_trigger_config_tb.sv ***
// self-checking bench of the external request block
`timescale 1ns/100ps
`include "ext_irq_consts.svh"
module ext_irq_trigger_config_tb;
  localparam logic [31:0] BASE = 32'h44444444; // rising edge everywhere
  logic                     clk = 1'b0;
  logic                     srst = 1'b1;
  ext_irq_pkg::bus_req_type bus_req = '0;
  logic [31:0]              rdata_q, r, d, a;
  logic [23:0]              lvl = 24'h0, pins, request_q;
  logic                     osc, irq_q;
  int                       n_fail = 0, samples_checked = 0, hits = 0, sel = 0, cyc = 0, h0 = 0;
  int                       seed = 32'h57402237;
  always #12.5 clk = ~clk;
  ext_irq_source u_src (.clk(clk), .level_cmd(lvl), .external_request_input(pins), .filter_osc_clk(osc));
  ext_irq_trigger_config DUT (.clk(clk), .srst(srst), .bus_req(bus_req), .rdata_q(rdata_q),
    .external_request_input(pins), .filter_osc_clk(osc), .request_q(request_q), .irq_q(irq_q));
  // ==================================
  // pulse counter on the watched input, and watchdog
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (request_q[sel] === 1'b1) hits <= hits + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr32(input logic [31:0] ad, dat);
    @(posedge clk);
    bus_req <= '{ad, dat, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr32
  // read data taken in the one cycle it stands
  task automatic rd32(input logic [31:0] ad, output logic [31:0] q);
    @(posedge clk);
    bus_req <= '{ad, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 q = rdata_q;
  endtask : rd32
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // ==================================
  // expectations
  function automatic logic [31:0] exp_level(input logic [2:0] c, input logic pin);
    return 32'((c == `CODE_LOW && !pin) || (c == `CODE_HIGH && pin));
  endfunction : exp_level
  function automatic logic [31:0] exp_edges(input int k, input logic [2:0] c, input logic rise);
    return 32'(c[2:1] == (rise ? `CODE_RISE : `CODE_FALL) || (c[2:1] == `CODE_BOTH && k >= 8));
  endfunction : exp_edges
  // ==================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rd32(`TRIG_LOW_ADDR + 4 * i, r);
      chk("cfg reset", r, `CFG_RESET);
    end
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      a = `TRIG_LOW_ADDR + 4 * (i % 3);
      wr32(a, d);
      rd32(a, r);
      chk("cfg readback", r, (i % 3 == 0) ? d & `LOW_VALID_MASK : d);
    end
    foreach (lvl[i]) begin
      a = i[0] ? 32'h560000ac : 32'h56000084;
      wr32(a, 32'hffffffff);
      rd32(a, r);
      chk("unmapped", r, 32'h0);
    end
    $display("test registers done");
    for (int k = 0; k < 24; k++) for (int c = 0; c < 8; c++) begin
      sel = k;
      a = `TRIG_LOW_ADDR + 4 * (k / 8);
      wr32(a, (BASE & ~(32'hf << 4 * (k % 8))) | (32'(c) << 4 * (k % 8)));
      tick(12);
      h0 = hits;
      lvl[k] = 1'b1;
      tick(12);
      chk("level high", 32'(request_q[k]), exp_level(3'(c), 1'b1));
      if (c > 1) chk("rise count", 32'(hits - h0), exp_edges(k, 3'(c), 1'b1));
      h0 = hits;
      lvl[k] = 1'b0;
      tick(12);
      chk("level low", 32'(request_q[k]), exp_level(3'(c), 1'b0));
      if (c > 1) chk("fall count", 32'(hits - h0), exp_edges(k, 3'(c), 1'b0));
      wr32(a, BASE);
    end
    $display("test modes done");
    sel = 9;
    wr32(`TRIG_MID_ADDR, BASE | 32'h80);
    for (int j = 0; j < 2; j++) begin
      wr32(`FILT_BASE_ADDR, j ? 32'h8600 : 32'h600);
      tick(30);
      h0 = hits;
      lvl[9] = 1'b1;
      tick(3);
      lvl[9] = 1'b0;
      tick(30);
      chk("short pulse", 32'(hits - h0), 32'h0);
      lvl[9] = 1'b1;
      tick(30);
      chk("long pulse", 32'(hits - h0), 32'h1);
      lvl[9] = 1'b0;
    end
    $display("test filter done");
    wr32(`TRIG_MID_ADDR, BASE);
    tick(12);
    wr32(`IRQ_STAT_ADDR, 32'h00ffffff);
    wr32(`IRQ_MASK_ADDR, 32'h0);
    lvl[9] = 1'b1;
    tick(12);
    rd32(`IRQ_STAT_ADDR, r);
    chk("status", r, 32'h200);
    chk("irq masked", 32'(irq_q), 32'h0);
    wr32(`IRQ_MASK_ADDR, 32'h200);
    tick(3);
    chk("irq on", 32'(irq_q), 32'h1);
    wr32(`IRQ_STAT_ADDR, 32'h200);
    tick(3);
    chk("irq cleared", 32'(irq_q), 32'h0);
    $display("test interrupt done");
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd32(`TRIG_MID_ADDR, r);
    chk("second reset", r, `CFG_RESET);
    $display("test reset done");
    end_of_test();
  end
endmodule : ext_irq_trigger_config_tb
